/* File: rtl/frm_pkg.sv */
package frm_pkg;

  // Bus and array geometry
  localparam int PADDR_W    = 8;
  localparam int FADDR_W    = 20;
  localparam int FDATA_W    = 16;
  localparam int PM1_W      = 8;
  localparam int NUM_BLK    = 8;
  localparam int BLK_W      = 3;
  localparam int BLK_LSB    = 16;
  localparam int BOOT_BYTES = 4096;
  localparam int BOOT_AW    = $clog2(BOOT_BYTES);
  localparam logic [BLK_W-1:0] BLK_LAST = 3'h7;

  // Register byte offsets
  localparam logic [PADDR_W-1:0] OFF_FLASH_MODE_REG_0   = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_PM1    = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_CMD    = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_ADDR   = 8'h0C;
  localparam logic [PADDR_W-1:0] OFF_DATA   = 8'h10;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h14;
  localparam logic [PADDR_W-1:0] OFF_LOCK   = 8'h18;

  // Field positions
  localparam int FLASH_MODE_REG_0_VARIANT_BIT = 0;
  localparam int FLASH_MODE_REG_0_REWEN_BIT   = 1;
  localparam int PM1_BIT0         = 0;
  localparam int PM1_BIT3         = 3;
  localparam int STAT_BUSY        = 0;
  localparam int STAT_REFUSED     = 1;
  localparam int STAT_OPERR       = 2;
  localparam int STAT_LOCKVAL     = 3;
  localparam int STAT_BOOT        = 4;
  localparam int STAT_PAR         = 5;
  localparam int STAT_UART        = 6;
  localparam int STAT_RDSTAT      = 7;

  // Reset values
  localparam logic [PM1_W-1:0]   PM1_RST  = 8'h00;
  localparam logic [NUM_BLK-1:0] LOCK_RST = 8'hFF;

  // Command set
  typedef enum logic [2:0] {
    CMD_READ_ARRAY   = 3'h0,
    CMD_READ_STATUS  = 3'h1,
    CMD_CLEAR_STATUS = 3'h2,
    CMD_PROGRAM      = 3'h3,
    CMD_BLOCK_ERASE  = 3'h4,
    CMD_ERASE_ALL    = 3'h5,
    CMD_LOCK_BLOCK   = 3'h6,
    CMD_READ_LOCK    = 3'h7
  } frm_cmd_t;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SCAN = 3'h2,
    ST_OP   = 3'h4
  } frm_state_t;

endpackage : frm_pkg

/* File: rtl/frm_permit.sv */
`timescale 1ns/1ps
// Decides whether a modifying command may touch the addressed area
module frm_permit
  import frm_pkg::*;
(
  input  wire logic src_cpu,
  input  wire logic src_ser,
  input  wire logic src_par,
  input  wire logic boot_area,
  input  wire logic blk_locked,
  input  wire logic ram_variant,
  input  wire logic fetch_in_flash,
  input  wire logic protect_on,
  output wire logic allow
);

  wire logic any_src;
  wire logic boot_ok;
  wire logic prot_ok;
  wire logic ew_ok;

  // Only the three rewrite sources exist; none active means no rewrite
  assign any_src = src_cpu | src_ser | src_par;
  // Boot area only from the parallel programmer
  assign boot_ok = ~boot_area | src_par;
  // Code protection guards both external programmer modes
  assign prot_ok = ~((src_ser | src_par) & protect_on);
  // RAM-resident variant must not run from the array it alters
  assign ew_ok   = ~(src_cpu & ram_variant & fetch_in_flash);
  assign allow   = any_src & boot_ok & prot_ok & ew_ok
                 & ~blk_locked;

endmodule : frm_permit

/* File: rtl/frm_ctrl.sv */
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
// What this block does
// - Exactly three rewrite sources: CPU, serial, parallel
// - Boot area is one 4 Kbyte erase block
// - Boot area rewrite refused outside parallel mode
// - Program one word; erase all or block
// - Operations start only by eight software commands
// - Lock bit per block blocks program, erase
// - Protection guards serial and parallel programmer modes
// - CPU rewrite touches user area only
// - RAM variant refuses modifying commands fetched from flash
// - Serial programmer user area; sync or UART
// - Parallel programmer rewrites boot and user areas
// - Enter from single chip; boot needs RAM variant
// - Mode bit 3 reads one while enabled
// - Clearing enable restores saved mode bit 3
// - Bit 3 writes held until enable clears
// - Entry sets mode bits 0 and 3
module frm_ctrl
  import frm_pkg::*;
(
  input  wire logic               CLK,
  input  wire logic               RESET,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [PADDR_W-1:0] PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic               BOOT_SELECT_PIN,
  input  wire logic               MODE_STRAP_PIN,
  input  wire logic               PORT5_BIT0_STRAP,
  input  wire logic               PARALLEL_MODE,
  input  wire logic               SERIAL_UART,
  input  wire logic               PROTECT_ACTIVE,
  input  wire logic               CPU_FETCH_IN_FLASH,
  input  wire logic               EXT_CMD_VALID,
  input  wire logic [2:0]         EXT_CMD,
  input  wire logic [FADDR_W-1:0] EXT_ADDR,
  input  wire logic [FDATA_W-1:0] EXT_WDATA,
  input  wire logic               EXT_BOOT_AREA,
  output logic                    EXT_CMD_ACCEPT,
  output logic                    EXT_CMD_REJECT,
  output logic                    FLASH_PROG_REQ,
  output logic                    FLASH_ERASE_REQ,
  output logic      [FADDR_W-1:0] FLASH_ADDR,
  output logic      [FDATA_W-1:0] FLASH_WDATA,
  output logic                    FLASH_BOOT_SEL,
  input  wire logic               FLASH_DONE,
  input  wire logic               FLASH_FAIL,
  output logic                    READ_ENABLE,
  output logic                    CPU_REWRITE,
  output logic      [PM1_W-1:0]   PM1_VALUE
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic               pready_reg, pslverr_reg;
  logic [31:0]        prdata_reg;
  logic               variant_reg, variant_next;
  logic               rew_en_reg, rew_en_next;
  logic [PM1_W-1:0]   pm1_reg, pm1_next;
  logic               processor_mode1_bit3_saved_reg, processor_mode1_bit3_saved_next;
  logic [FADDR_W-1:0] cmd_addr_reg;
  logic [FDATA_W-1:0] cmd_data_reg;
  logic [NUM_BLK-1:0] lock_reg, lock_next;
  logic               refused_reg, operr_reg, lockval_reg, lockval_next;
  logic               rdstat_reg, rdstat_next;
  logic               boot_mode_reg, read_en_reg;
  frm_state_t         state_reg, state_next;
  logic               all_reg, all_next;
  logic [BLK_W-1:0]   idx_reg, idx_next;
  logic               prog_reg, prog_next, erase_reg, erase_next;
  logic [FADDR_W-1:0] faddr_reg, faddr_next;
  logic [FDATA_W-1:0] fdata_reg, fdata_next;
  logic               fboot_reg, fboot_next;
  logic               acc_reg, acc_next, rej_reg, rej_next;
  logic               refused_set, operr_set, stat_clr;
  logic [31:0]        stat_word;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state, write lands at the completing edge
  wire logic apb_acc  = PSEL & PENABLE & ~pready_reg;
  wire logic apb_done = PSEL & PENABLE & pready_reg;
  wire logic a_flash_mode_reg_0   = (PADDR == OFF_FLASH_MODE_REG_0);
  wire logic a_pm1    = (PADDR == OFF_PM1);
  wire logic a_cmd    = (PADDR == OFF_CMD);
  wire logic a_addr   = (PADDR == OFF_ADDR);
  wire logic a_data   = (PADDR == OFF_DATA);
  wire logic a_stat   = (PADDR == OFF_STATUS);
  wire logic a_lock   = (PADDR == OFF_LOCK);
  wire logic mapped   = a_flash_mode_reg_0 | a_pm1 | a_cmd | a_addr | a_data
                      | a_stat | a_lock;
  wire logic bad_acc  = ~mapped | (PWRITE & (a_stat | a_lock));
  wire logic wr_en    = apb_done & PWRITE & ~pslverr_reg;
  wire logic wr_flash_mode_reg_0  = wr_en & a_flash_mode_reg_0;
  wire logic wr_pm1   = wr_en & a_pm1;
  wire logic wr_cmd   = wr_en & a_cmd;

  // Read mux; the command register reads back as zero
  wire logic [31:0] rd_mux =
      a_flash_mode_reg_0 ? 32'({rew_en_reg, variant_reg}) :
      a_pm1  ? 32'(pm1_reg) :
      a_addr ? 32'(cmd_addr_reg) :
      a_data ? 32'(cmd_data_reg) :
      a_stat ? stat_word :
      a_lock ? 32'(lock_reg) : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Rewrite source; pins pick external modes, software picks CPU
  wire logic src_par = PARALLEL_MODE;
  wire logic src_cpu = ~PARALLEL_MODE & rew_en_reg;
  wire logic src_ser = ~PARALLEL_MODE & ~rew_en_reg
                     & boot_mode_reg;
  wire logic idle    = (state_reg == ST_IDLE);

  // Enable request; boot mode only takes the RAM-resident variant
  wire logic new_var = rew_en_reg ? variant_reg
                                  : PWDATA[FLASH_MODE_REG_0_VARIANT_BIT];
  wire logic set_ok  = ~PARALLEL_MODE & (~boot_mode_reg | ~new_var);
  wire logic entering = wr_flash_mode_reg_0 & ~rew_en_reg & PWDATA[FLASH_MODE_REG_0_REWEN_BIT]
                      & set_ok;
  wire logic leaving  = wr_flash_mode_reg_0 & rew_en_reg & ~PWDATA[FLASH_MODE_REG_0_REWEN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Command intake from CPU (APB) or external programmer
  wire logic cpu_go  = wr_cmd & src_cpu & idle;
  wire logic ext_go  = (src_ser | src_par) & EXT_CMD_VALID & idle
                     & ~acc_reg & ~rej_reg;
  wire logic go      = cpu_go | ext_go;
  wire frm_cmd_t cmd_sel = cpu_go ? frm_cmd_t'(PWDATA[2:0])
                                  : frm_cmd_t'(EXT_CMD);
  wire logic [FADDR_W-1:0] addr_sel = cpu_go ? cmd_addr_reg : EXT_ADDR;
  wire logic [FDATA_W-1:0] data_sel = cpu_go ? cmd_data_reg : EXT_WDATA;
  wire logic boot_sel  = ~cpu_go & EXT_BOOT_AREA;
  wire logic [BLK_W-1:0] blk_sel = addr_sel[BLK_LSB +: BLK_W];
  wire logic is_erall  = (cmd_sel == CMD_ERASE_ALL);
  wire logic is_modify = (cmd_sel == CMD_PROGRAM)
                       | (cmd_sel == CMD_BLOCK_ERASE)
                       | (cmd_sel == CMD_LOCK_BLOCK) | is_erall;
  // Boot block has no lock bit; erase-all checks locks block by block
  wire logic blk_locked = ~boot_sel & ~is_erall & ~lock_reg[blk_sel];
  wire logic allow;
  wire logic deny = is_modify & ~allow;

  frm_permit u_permit (
    .src_cpu        (src_cpu),
    .src_ser        (src_ser),
    .src_par        (src_par),
    .boot_area      (boot_sel),
    .blk_locked     (blk_locked),
    .ram_variant    (~variant_reg),
    .fetch_in_flash (CPU_FETCH_IN_FLASH),
    .protect_on     (PROTECT_ACTIVE),
    .allow          (allow)
  );

  // Boot area is one block: its address folds into 4 Kbytes
  wire logic [FADDR_W-1:0] op_addr =
      boot_sel ? FADDR_W'(addr_sel[BOOT_AW-1:0]) : addr_sel;
  wire logic [FADDR_W-1:0] scan_addr =
      FADDR_W'({idx_reg, {BLK_LSB{1'b0}}});

  ////////////////////////////////////////////////////////////////////////////
  // Mode register bits; bit 3 pinned while CPU rewrite is on
  always_comb
  begin
    pm1_next        = pm1_reg;
    processor_mode1_bit3_saved_next = processor_mode1_bit3_saved_reg;
    rew_en_next     = rew_en_reg;
    variant_next    = variant_reg;
    if (wr_flash_mode_reg_0)
    begin
      variant_next = new_var;
      rew_en_next  = PWDATA[FLASH_MODE_REG_0_REWEN_BIT] & (rew_en_reg | set_ok);
    end
    if (entering)
    begin
      processor_mode1_bit3_saved_next    = pm1_reg[PM1_BIT3];
      pm1_next[PM1_BIT0] = 1'b1;
      pm1_next[PM1_BIT3] = 1'b1;
    end
    else if (leaving)
      pm1_next[PM1_BIT3] = processor_mode1_bit3_saved_reg;
    else if (wr_pm1)
    begin
      pm1_next = PWDATA[PM1_W-1:0];
      if (rew_en_reg)
      begin
        // Bit 3 stays forced; the write waits in the shadow
        pm1_next[PM1_BIT3] = 1'b1;
        processor_mode1_bit3_saved_next    = PWDATA[PM1_BIT3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; one word or one block per flash request
  always_comb
  begin
    state_next   = state_reg;
    all_next     = all_reg;
    idx_next     = idx_reg;
    prog_next    = 1'b0;
    erase_next   = 1'b0;
    faddr_next   = faddr_reg;
    fdata_next   = fdata_reg;
    fboot_next   = fboot_reg;
    lock_next    = lock_reg;
    lockval_next = lockval_reg;
    rdstat_next  = rdstat_reg;
    acc_next     = ext_go & ~deny;
    rej_next     = ext_go & deny;
    refused_set  = (wr_cmd & ~cpu_go) | (go & deny);
    operr_set    = 1'b0;
    stat_clr     = 1'b0;
    unique case (state_reg)
      ST_IDLE:
        if (go & ~deny)
        begin
          unique case (cmd_sel)
            CMD_READ_ARRAY:   rdstat_next = 1'b0;
            CMD_READ_STATUS:  rdstat_next = 1'b1;
            CMD_CLEAR_STATUS: stat_clr = 1'b1;
            CMD_READ_LOCK:    lockval_next = boot_sel | lock_reg[blk_sel];
            CMD_LOCK_BLOCK:   if (!boot_sel) lock_next[blk_sel] = 1'b0;
            CMD_PROGRAM:
            begin
              prog_next  = 1'b1;
              faddr_next = op_addr;
              fdata_next = data_sel;
              fboot_next = boot_sel;
              state_next = ST_OP;
            end
            CMD_BLOCK_ERASE:
            begin
              erase_next = 1'b1;
              faddr_next = op_addr;
              fboot_next = boot_sel;
              state_next = ST_OP;
            end
            CMD_ERASE_ALL:
            begin
              all_next   = 1'b1;
              idx_next   = '0;
              state_next = ST_SCAN;
            end
          endcase
        end
      ST_SCAN:
        if (lock_reg[idx_reg])
        begin
          erase_next = 1'b1;
          faddr_next = scan_addr;
          fboot_next = 1'b0;
          state_next = ST_OP;
        end
        else if (idx_reg == BLK_LAST)
        begin
          all_next   = 1'b0;
          state_next = ST_IDLE;
        end
        else
          idx_next = idx_reg + 3'h1;
      ST_OP:
        if (FLASH_DONE)
        begin
          operr_set = FLASH_FAIL;
          if (all_reg && idx_reg != BLK_LAST)
          begin
            idx_next   = idx_reg + 3'h1;
            state_next = ST_SCAN;
          end
          else
          begin
            all_next   = 1'b0;
            state_next = ST_IDLE;
            // RAM-resident variant leaves status readable afterwards
            rdstat_next = src_cpu & ~variant_reg;
          end
        end
      default:
        state_next = ST_IDLE;
    endcase
  end

  // Status view of the block's state plus the parallel and UART mode pins
  always_comb
  begin
    stat_word               = 32'h0000_0000;
    stat_word[STAT_BUSY]    = ~idle;
    stat_word[STAT_REFUSED] = refused_reg;
    stat_word[STAT_OPERR]   = operr_reg;
    stat_word[STAT_LOCKVAL] = lockval_reg;
    stat_word[STAT_BOOT]    = boot_mode_reg;
    stat_word[STAT_PAR]     = PARALLEL_MODE;
    stat_word[STAT_UART]    = SERIAL_UART;
    stat_word[STAT_RDSTAT]  = rdstat_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Boot strap capture while reset is held
  always_ff @(posedge CLK)
    if (RESET)
      boot_mode_reg <= BOOT_SELECT_PIN & PORT5_BIT0_STRAP
                     & ~MODE_STRAP_PIN;
  // APB slave registers
  always_ff @(posedge CLK)
    if (RESET)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= apb_acc;
      pslverr_reg <= apb_acc & bad_acc;
      prdata_reg  <= (apb_acc & ~PWRITE) ? rd_mux : 32'h0000_0000;
    end

  // Software-visible control
  always_ff @(posedge CLK)
    if (RESET)
    begin
      rew_en_reg     <= 1'b0;
      variant_reg    <= 1'b0;
      pm1_reg        <= PM1_RST;
      processor_mode1_bit3_saved_reg <= 1'b0;
      cmd_addr_reg   <= '0;
      cmd_data_reg   <= '0;
    end
    else
    begin
      rew_en_reg     <= rew_en_next;
      variant_reg    <= variant_next;
      pm1_reg        <= pm1_next;
      processor_mode1_bit3_saved_reg <= processor_mode1_bit3_saved_next;
      if (wr_en & a_addr) cmd_addr_reg <= PWDATA[FADDR_W-1:0];
      if (wr_en & a_data) cmd_data_reg <= PWDATA[FDATA_W-1:0];
    end

  // Sequencer and flags; a new event beats a clear in the same cycle
  always_ff @(posedge CLK)
    if (RESET)
    begin
      state_reg   <= ST_IDLE;
      all_reg     <= 1'b0;
      idx_reg     <= '0;
      lock_reg    <= LOCK_RST;
      refused_reg <= 1'b0;
      operr_reg   <= 1'b0;
      lockval_reg <= 1'b0;
      rdstat_reg  <= 1'b0;
      read_en_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= state_next;
      all_reg     <= all_next;
      idx_reg     <= idx_next;
      lock_reg    <= lock_next;
      refused_reg <= refused_set | (refused_reg & ~stat_clr);
      operr_reg   <= operr_set | (operr_reg & ~stat_clr);
      lockval_reg <= lockval_next;
      rdstat_reg  <= rdstat_next;
      read_en_reg <= ~((src_ser | src_par) & PROTECT_ACTIVE);
    end

  // Flash request and handshake outputs
  always_ff @(posedge CLK)
    if (RESET)
    begin
      prog_reg  <= 1'b0;
      erase_reg <= 1'b0;
      faddr_reg <= '0;
      fdata_reg <= '0;
      fboot_reg <= 1'b0;
      acc_reg   <= 1'b0;
      rej_reg   <= 1'b0;
    end
    else
    begin
      prog_reg  <= prog_next;
      erase_reg <= erase_next;
      faddr_reg <= faddr_next;
      fdata_reg <= fdata_next;
      fboot_reg <= fboot_next;
      acc_reg   <= acc_next;
      rej_reg   <= rej_next;
    end

  assign PRDATA          = prdata_reg;
  assign PREADY          = pready_reg;
  assign PSLVERR         = pslverr_reg;
  assign EXT_CMD_ACCEPT  = acc_reg;
  assign EXT_CMD_REJECT  = rej_reg;
  assign FLASH_PROG_REQ  = prog_reg;
  assign FLASH_ERASE_REQ = erase_reg;
  assign FLASH_ADDR      = faddr_reg;
  assign FLASH_WDATA     = fdata_reg;
  assign FLASH_BOOT_SEL  = fboot_reg;
  assign READ_ENABLE     = read_en_reg;
  assign CPU_REWRITE     = rew_en_reg;
  assign PM1_VALUE       = pm1_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_one_source: assert property ($onehot0({src_cpu, src_ser, src_par}))
    else $error("more than one rewrite source active");
  a_boot_par_only: assert property ((prog_reg | erase_reg) && fboot_reg
    |-> src_par)
    else $error("boot area rewrite outside parallel mode");
  a_boot_fold: assert property (fboot_reg && (prog_reg | erase_reg)
    |-> faddr_reg[FADDR_W-1:BOOT_AW] == '0)
    else $error("boot address outside 4 Kbyte block");
  a_lock_honored: assert property ((prog_reg | erase_reg) && !fboot_reg
    |-> lock_reg[faddr_reg[BLK_LSB +: BLK_W]])
    else $error("locked block programmed or erased");
  a_word_request: assert property (prog_reg |-> state_reg == ST_OP
    ##1 !prog_reg)
    else $error("program request not a single word pulse");
  a_ram_variant: assert property (cpu_go && is_modify && !variant_reg
    && CPU_FETCH_IN_FLASH |=> !prog_reg && !erase_reg && refused_reg)
    else $error("RAM variant accepted command fetched from flash");
  a_protect_read: assert property (src_par && PROTECT_ACTIVE
    |=> !READ_ENABLE)
    else $error("protected array readable");
  a_boot_entry: assert property ($rose(rew_en_reg) && boot_mode_reg
    |-> !variant_reg)
    else $error("boot mode entered flash-resident variant");
  a_processor_mode1_bit3_forced: assert property (rew_en_reg |-> pm1_reg[PM1_BIT3])
    else $error("mode bit 3 not forced during rewrite");
  a_pm_entry: assert property ($rose(rew_en_reg)
    |-> pm1_reg[PM1_BIT0] && pm1_reg[PM1_BIT3])
    else $error("entry did not set mode bits 0 and 3");
  a_processor_mode1_bit3_restore: assert property ($fell(rew_en_reg)
    |-> pm1_reg[PM1_BIT3] == $past(processor_mode1_bit3_saved_reg))
    else $error("mode bit 3 not restored on exit");
  a_processor_mode1_bit3_defer: assert property (wr_pm1 && rew_en_reg && !leaving
    |=> processor_mode1_bit3_saved_reg == $past(PWDATA[PM1_BIT3]) && pm1_reg[PM1_BIT3])
    else $error("mode bit 3 write not held back");
  a_apb_answer: assert property (apb_acc |=> PREADY ##1 !PREADY)
    else $error("APB answer not one wait state");

  c_cpu_program: cover property (cpu_go && cmd_sel == CMD_PROGRAM
    ##1 prog_reg);
  c_erase_all: cover property (state_reg == ST_SCAN && idx_reg == BLK_LAST
    ##[1:8] idle);
  c_boot_erase: cover property (erase_reg && fboot_reg);
  c_pm_restore: cover property ($fell(rew_en_reg));

endmodule : frm_ctrl

/* File: test/frm_flash_model.sv */
`timescale 1ns/1ps
// Flash macro stand-in: each request pulse is one operation, answered late
module frm_flash_model
  import frm_pkg::*;
#(
  parameter int DELAY = 3
)
(
  input  wire logic CLK,
  input  wire logic RESET,
  input  wire logic FLASH_PROG_REQ,
  input  wire logic FLASH_ERASE_REQ,
  output logic      FLASH_DONE,
  output logic      FLASH_FAIL
);
  int cnt_reg;
  // Countdown so the sequencer never gets an answer in the same cycle
  always_ff @(posedge CLK)
  begin
    if (RESET || FLASH_PROG_REQ || FLASH_ERASE_REQ)
      cnt_reg <= RESET ? 0 : DELAY;
    else if (cnt_reg != 0)
      cnt_reg <= cnt_reg - 1;
  end
  // Done is a one-cycle pulse; fail stays low, no scenario needs it
  assign FLASH_DONE = (cnt_reg == 1);
  assign FLASH_FAIL = 1'b0;
endmodule : frm_flash_model

/* File: test/test_frm_ctrl.sv */
`timescale 1ns/1ps
module test_frm_ctrl
  import frm_pkg::*;
;
  logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [PADDR_W-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd_val;
  logic PREADY, PSLVERR, EXT_CMD_ACCEPT, EXT_CMD_REJECT, bus_err, acc;
  logic BOOT_SELECT_PIN = 0, MODE_STRAP_PIN = 0, PORT5_BIT0_STRAP = 0;
  logic PARALLEL_MODE = 0, SERIAL_UART = 0, PROTECT_ACTIVE = 0;
  logic CPU_FETCH_IN_FLASH = 0, EXT_CMD_VALID = 0, EXT_BOOT_AREA = 0;
  logic [2:0] EXT_CMD = '0;
  logic [FADDR_W-1:0] EXT_ADDR = '0, FLASH_ADDR, prog_addr;
  logic [FDATA_W-1:0] EXT_WDATA = '0, FLASH_WDATA, prog_data;
  logic FLASH_PROG_REQ, FLASH_ERASE_REQ, FLASH_BOOT_SEL, prog_boot;
  logic FLASH_DONE, FLASH_FAIL, READ_ENABLE, CPU_REWRITE;
  logic [PM1_W-1:0] PM1_VALUE;
  int err_count = 0, n_compared = 0, cyc = 0, n_prog = 0, n_erase = 0;
  always #50 CLK = ~CLK;
  frm_ctrl dut_u (.*);
  frm_flash_model #(.DELAY(3)) flash_u (.*);
  ////////////////////////////////////////////////////////////////////////////
  // Count macro requests, keep what the last program carried, cut hangs
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    n_erase <= n_erase + (FLASH_ERASE_REQ === 1'b1);
    if (FLASH_PROG_REQ === 1'b1)
    begin
      n_prog <= n_prog + 1;
      prog_addr <= FLASH_ADDR;
      prog_data <= FLASH_WDATA;
      prog_boot <= FLASH_BOOT_SEL;
    end
    if (cyc == 20000)
    begin
      err_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One APB transfer; an idle cycle after it keeps drivers single per step
  task automatic apb(input logic w, input logic [PADDR_W-1:0] a,
                     input logic [31:0] d);
    int n = 0;
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 50);
    rd_val = PRDATA;
    bus_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb
  task automatic rdc(input logic [PADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd_val, e);
  endtask : rdc
  // Poll busy with a bound; the macro answers after a few cycles
  task automatic wait_idle();
    int n = 0;
    do
    begin
      apb(1'b0, OFF_STATUS, 32'h0000_0000);
      n++;
    end
    while (rd_val[STAT_BUSY] !== 1'b0 && n < 30);
  endtask : wait_idle
  // Programmer-side program request; valid drops in the answer cycle
  task automatic ext(input logic b);
    int n = 0;
    EXT_CMD_VALID <= 1'b1;
    EXT_CMD <= CMD_PROGRAM;
    EXT_ADDR <= 20'h2_2345;
    EXT_WDATA <= 16'h5A5A;
    EXT_BOOT_AREA <= b;
    do
    begin
      @(posedge CLK);
      n++;
    end
    while (EXT_CMD_ACCEPT !== 1'b1 && EXT_CMD_REJECT !== 1'b1 && n < 20);
    acc = EXT_CMD_ACCEPT;
    EXT_CMD_VALID <= 1'b0;
    @(posedge CLK);
  endtask : ext
  ////////////////////////////////////////////////////////////////////////////
  // Straps stay low, so the part starts in single-chip mode
  initial
  begin
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    rdc(OFF_LOCK, 32'h0000_00FF);
    apb(1'b1, OFF_PM1, 32'h0000_0008);
    apb(1'b1, OFF_FLASH_MODE_REG_0, 32'h0000_0002);
    rdc(OFF_PM1, 32'h0000_0009);
    chk({31'h0, CPU_REWRITE}, 32'h0000_0001);
    apb(1'b1, OFF_PM1, 32'h0000_0001);
    rdc(OFF_PM1, 32'h0000_0009);
    apb(1'b1, OFF_ADDR, 32'h0001_0002);
    apb(1'b1, OFF_DATA, 32'h0000_BEEF);
    apb(1'b1, OFF_CMD, 32'h0000_0003);
    wait_idle();
    chk(n_prog, 1);
    chk({12'h0, prog_addr}, 32'h0001_0002);
    chk({16'h0, prog_data}, 32'h0000_BEEF);
    apb(1'b1, OFF_CMD, 32'h0000_0006);
    rdc(OFF_LOCK, 32'h0000_00FD);
    apb(1'b1, OFF_CMD, 32'h0000_0003);
    wait_idle();
    chk(n_prog, 1);
    chk(rd_val & 32'h0000_0002, 32'h0000_0002);
    apb(1'b1, OFF_CMD, 32'h0000_0002);
    apb(1'b1, OFF_CMD, 32'h0000_0005);
    wait_idle();
    chk(n_erase, 7);
    chk(rd_val & 32'h0000_0002, 32'h0000_0000);
    CPU_FETCH_IN_FLASH <= 1'b1;
    apb(1'b1, OFF_ADDR, 32'h0002_0000);
    apb(1'b1, OFF_CMD, 32'h0000_0003);
    wait_idle();
    chk(n_prog, 1);
    CPU_FETCH_IN_FLASH <= 1'b0;
    apb(1'b1, OFF_FLASH_MODE_REG_0, 32'h0000_0000);
    rdc(OFF_PM1, 32'h0000_0001);
    chk({24'h0, PM1_VALUE}, 32'h0000_0001);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk({31'h0, bus_err}, 32'h0000_0001); // Unmapped offset
    apb(1'b1, OFF_STATUS, 32'h0000_00FF);
    chk({31'h0, bus_err}, 32'h0000_0001); // Read-only register
    PARALLEL_MODE <= 1'b1;
    apb(1'b1, OFF_FLASH_MODE_REG_0, 32'h0000_0002);
    chk({31'h0, CPU_REWRITE}, 32'h0000_0000);
    ext(1'b1);
    chk({31'h0, acc}, 32'h0000_0001);
    chk({31'h0, prog_boot}, 32'h0000_0001);
    chk({12'h0, prog_addr}, 32'h0000_0345);
    wait_idle();
    PROTECT_ACTIVE <= 1'b1;
    ext(1'b0);
    chk({31'h0, acc}, 32'h0000_0000);
    chk({31'h0, READ_ENABLE}, 32'h0000_0000);
    chk(n_prog, 2);
    end_of_test();
  end
endmodule : test_frm_ctrl
